// ### pwrmon_pkg.sv
// constants for the power monitor configuration register and its decode
// assumes a 10 MHz system clock and a serial slave that delivers words
// Functional notes
// R1 - active bit 6 low shuts down the measurement path; writing one reactivates
// R2 - mux field bits 5:4 selects bus, shunt, supply power, load power
// R3 - supply power mode routes supply-side input to bus sampling path
// R4 - load power mode routes load-side input to bus sampling path
// R5 - bus voltage mode always samples bus at supply-side input
// R6 - shunt gain bits 3:2 select 20, 128, 300; code 11 undefined
// R7 - bus attenuation bits 1:0 select 2/5, 1/5, 1/10; 11 undefined
// R8 - reset value is active, supply power, gain 20, attenuation 1/5
// R9 - power scaling factor follows from both gain codes per table
// R10 - output valid only about 40 us after leaving shutdown
// R11 - general call 81h sets active bit, 82h clears it
// R12 - bits 15 to 7 read zero and ignore writes
// R13 - master must never write code 11 into either gain field
package pwrmon_pkg;
  localparam int unsigned REG_W = 16;
  localparam logic [15:0] CFG_RESET = 16'h0061;
  localparam logic [15:0] CFG_WMASK = 16'h007F;
  localparam int unsigned ACTIVE_BIT = 6;
  localparam int unsigned MUX_HI = 5;
  localparam int unsigned MUX_LO = 4;
  localparam int unsigned GAIN_HI = 3;
  localparam int unsigned GAIN_LO = 2;
  localparam int unsigned ATTEN_HI = 1;
  localparam int unsigned ATTEN_LO = 0;
  localparam logic [7:0] GC_ENABLE = 8'h81;
  localparam logic [7:0] GC_DISABLE = 8'h82;
  localparam int unsigned CLK_MHZ = 10;
  localparam int unsigned WAKE_US = 40;
  localparam int unsigned WAKE_CYCLES = WAKE_US * CLK_MHZ;
  localparam int unsigned WAKE_CW = 9;
  // power gain in thousandths
  localparam int unsigned PG_W = 16;
  typedef enum logic [1:0] {
    MODE_BUS = 2'b00,
    MODE_SHUNT = 2'b01,
    MODE_SUPPLY_PWR = 2'b10,
    MODE_LOAD_PWR = 2'b11
  } out_mode_t;
  typedef enum logic [1:0] {
    GAIN_20 = 2'b00,
    GAIN_128 = 2'b01,
    GAIN_300 = 2'b10,
    GAIN_UNDEF = 2'b11
  } shunt_gain_t;
  typedef enum logic [1:0] {
    ATT_2_5 = 2'b00,
    ATT_1_5 = 2'b01,
    ATT_1_10 = 2'b10,
    ATT_UNDEF = 2'b11
  } bus_atten_t;
endpackage : pwrmon_pkg

// ### power_gain_lut.sv
// power gain lookup in thousandths from shunt gain and bus attenuation
// assumes codes come straight from the configuration register
`timescale 1ns/100ps
module power_gain_lut (
  input wire logic [1:0] shunt_gain_i,
  input wire logic [1:0] bus_atten_i,
  output logic [15:0] power_gain_o,
  output logic valid_o
);
  always_comb begin
    power_gain_o = 16'h0000;
    valid_o = 1'b1;
    case ({bus_atten_i, shunt_gain_i}) // R9
      4'hA: power_gain_o = 16'h2710; // 10
      4'h9: power_gain_o = 16'h10AB; // 4.267
      4'h8: power_gain_o = 16'h029B; // 0.667
      4'h6: power_gain_o = 16'h4E20; // 20
      4'h5: power_gain_o = 16'h2155; // 8.533
      4'h4: power_gain_o = 16'h0535; // 1.333
      4'h2: power_gain_o = 16'h9C40; // 40
      4'h1: power_gain_o = 16'h42AB; // 17.067
      4'h0: power_gain_o = 16'h0A6B; // 2.667
      default: valid_o = 1'b0;
    endcase
  end
endmodule : power_gain_lut

// ### power_monitor_config_register.sv
// configuration register with analog switch decode and wake timing
// assumes a serial slave delivers decoded word writes and general calls
`timescale 1ns/100ps
module power_monitor_config_register #(
  parameter int unsigned WAKE_CYCLES = pwrmon_pkg::WAKE_CYCLES
) (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic wr_en_i,
  input wire logic [15:0] wr_data_i,
  input wire logic gc_valid_i,
  input wire logic [7:0] gc_cmd_i,
  output logic [15:0] rd_data_o,
  output logic active_o,
  output logic [1:0] mux_sel_o,
  output logic sample_supply_o,
  output logic sample_load_o,
  output logic [1:0] shunt_gain_o,
  output logic [1:0] bus_atten_o,
  output logic gain_sel_20_o,
  output logic gain_sel_128_o,
  output logic gain_sel_300_o,
  output logic atten_sel_2_5_o,
  output logic atten_sel_1_5_o,
  output logic atten_sel_1_10_o,
  output logic [15:0] power_gain_o,
  output logic gain_code_ok_o,
  output logic out_valid_o
);
  logic [6:0] cfg_reg;
  logic [6:0] cfg_next;
  logic [8:0] wake_reg;
  // wake count cut to the counter width; the defaults fit in 9 bits
  localparam logic [8:0] WAKE_LIMIT = WAKE_CYCLES[8:0];

  // --------------------------------------------------------------
  // register write and general call
  // --------------------------------------------------------------
  always_comb begin
    cfg_next = cfg_reg;
    if (wr_en_i) begin
      cfg_next = wr_data_i[6:0]; // R12
    end
    if (gc_valid_i && gc_cmd_i == pwrmon_pkg::GC_ENABLE) begin
      cfg_next[pwrmon_pkg::ACTIVE_BIT] = 1'b1; // R11
    end else if (gc_valid_i && gc_cmd_i == pwrmon_pkg::GC_DISABLE) begin
      cfg_next[pwrmon_pkg::ACTIVE_BIT] = 1'b0; // R11
    end
  end

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      cfg_reg <= pwrmon_pkg::CFG_RESET[6:0]; // R8
    end else begin
      cfg_reg <= cfg_next; // R1
    end
  end

  assign rd_data_o = {9'h000, cfg_reg}; // R12

  // --------------------------------------------------------------
  // analog decode
  // --------------------------------------------------------------
  assign active_o = cfg_reg[pwrmon_pkg::ACTIVE_BIT]; // R1
  assign mux_sel_o = cfg_reg[5:4]; // R2
  assign shunt_gain_o = cfg_reg[3:2]; // R6
  assign bus_atten_o = cfg_reg[1:0]; // R7

  always_comb begin
    sample_supply_o = 1'b0;
    sample_load_o = 1'b0;
    case (mux_sel_o)
      pwrmon_pkg::MODE_BUS: sample_supply_o = active_o; // R5
      pwrmon_pkg::MODE_SHUNT: sample_supply_o = 1'b0;
      pwrmon_pkg::MODE_SUPPLY_PWR: sample_supply_o = active_o; // R3
      pwrmon_pkg::MODE_LOAD_PWR: sample_load_o = active_o; // R4
      default: sample_supply_o = 1'b0;
    endcase
  end

  assign gain_sel_20_o = active_o && shunt_gain_o == pwrmon_pkg::GAIN_20; // R6
  assign gain_sel_128_o = active_o && shunt_gain_o == pwrmon_pkg::GAIN_128;
  assign gain_sel_300_o = active_o && shunt_gain_o == pwrmon_pkg::GAIN_300;
  assign atten_sel_2_5_o = active_o && bus_atten_o == pwrmon_pkg::ATT_2_5; // R7
  assign atten_sel_1_5_o = active_o && bus_atten_o == pwrmon_pkg::ATT_1_5;
  assign atten_sel_1_10_o = active_o && bus_atten_o == pwrmon_pkg::ATT_1_10;

  power_gain_lut u_lut (
    .shunt_gain_i(shunt_gain_o),
    .bus_atten_i(bus_atten_o),
    .power_gain_o(power_gain_o),
    .valid_o(gain_code_ok_o)
  );

  // --------------------------------------------------------------
  // wake timer
  // --------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      wake_reg <= 9'h000;
    end else begin
      if (!active_o) begin
        wake_reg <= 9'h000;
      end else if (wake_reg < WAKE_LIMIT) begin
        wake_reg <= wake_reg + 9'h001; // R10
      end
    end
  end

  // counting starts on the first cycle seen active, so a wake by write or
  // general call is always followed by the full settling time
  assign out_valid_o = active_o && wake_reg >= WAKE_LIMIT; // R10

  // --------------------------------------------------------------
  // assertion helpers
  // --------------------------------------------------------------
  // separate count of unbroken active cycles, saturating at all ones
  logic [9:0] awake_cnt_reg;

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      awake_cnt_reg <= 10'h000;
    end else if (!active_o) begin
      awake_cnt_reg <= 10'h000;
    end else if (awake_cnt_reg != 10'h3FF) begin
      awake_cnt_reg <= awake_cnt_reg + 10'h001;
    end
  end

  // --------------------------------------------------------------
  // assertions
  // --------------------------------------------------------------
  // wake start followed by a run of active cycles
  sequence s_wake;
    $rose(active_o) ##1 active_o [*8];
  endsequence

  // general call bytes that touch the active bit
  sequence s_gc_on;
    gc_valid_i && gc_cmd_i == pwrmon_pkg::GC_ENABLE;
  endsequence

  sequence s_gc_off;
    gc_valid_i && gc_cmd_i == pwrmon_pkg::GC_DISABLE;
  endsequence

  // a cycle that must leave the register alone
  sequence s_quiet;
    !wr_en_i && (!gc_valid_i || (gc_cmd_i != pwrmon_pkg::GC_ENABLE
      && gc_cmd_i != pwrmon_pkg::GC_DISABLE));
  endsequence

  // a write that would put the block into shutdown
  sequence s_write_clear;
    wr_en_i && !wr_data_i[pwrmon_pkg::ACTIVE_BIT];
  endsequence

  a_reserved_zero: assert property ( // R12
    @(posedge clk_i) disable iff (!rst_n_i)
    rd_data_o[15:7] == 9'h000)
    else $error("reserved bits nonzero");
  a_write_store: assert property ( // R1
    @(posedge clk_i) disable iff (!rst_n_i)
    wr_en_i && !gc_valid_i |=> rd_data_o[6:0] == $past(wr_data_i[6:0]))
    else $error("write not stored");
  a_gc_enable: assert property ( // R11
    @(posedge clk_i) disable iff (!rst_n_i)
    s_gc_on |=> active_o)
    else $error("general call enable failed");
  a_gc_disable: assert property ( // R11
    @(posedge clk_i) disable iff (!rst_n_i)
    s_gc_off |=> !active_o)
    else $error("general call disable failed");
  a_gc_override: assert property ( // R11
    @(posedge clk_i) disable iff (!rst_n_i)
    s_write_clear ##0 s_gc_on
    |=> active_o && rd_data_o[5:0] == $past(wr_data_i[5:0]))
    else $error("general call lost against write");
  a_hold_idle: assert property ( // R11
    @(posedge clk_i) disable iff (!rst_n_i)
    s_quiet |=> $stable(rd_data_o))
    else $error("register changed without write");
  a_reset_value: assert property ( // R8
    @(posedge clk_i)
    !rst_n_i |=> rd_data_o == 16'h0061)
    else $error("bad reset value");
  a_wake_early: assert property ( // R10
    @(posedge clk_i) disable iff (!rst_n_i)
    s_wake |-> !out_valid_o)
    else $error("valid too early");
  a_wake_short: assert property ( // R10
    @(posedge clk_i) disable iff (!rst_n_i)
    awake_cnt_reg < {1'b0, WAKE_LIMIT} |-> !out_valid_o)
    else $error("valid before settling time");
  a_wake_late: assert property ( // R10
    @(posedge clk_i) disable iff (!rst_n_i)
    active_o && awake_cnt_reg >= {1'b0, WAKE_LIMIT} |-> out_valid_o)
    else $error("valid missing after settling time");
  a_load_route: assert property ( // R4
    @(posedge clk_i) disable iff (!rst_n_i)
    active_o && mux_sel_o == 2'b11 |-> sample_load_o && !sample_supply_o)
    else $error("load route wrong");
  a_supply_route: assert property ( // R3
    @(posedge clk_i) disable iff (!rst_n_i)
    active_o && mux_sel_o[0] == 1'b0 |-> sample_supply_o && !sample_load_o)
    else $error("supply route wrong");
  a_bus_route: assert property ( // R5
    @(posedge clk_i) disable iff (!rst_n_i)
    active_o && mux_sel_o == pwrmon_pkg::MODE_BUS |-> sample_supply_o)
    else $error("bus voltage not at supply side");
  a_shunt_route: assert property ( // R2
    @(posedge clk_i) disable iff (!rst_n_i)
    mux_sel_o == pwrmon_pkg::MODE_SHUNT
    |-> !sample_supply_o && !sample_load_o)
    else $error("bus sampled in shunt mode");
  a_shutdown_off: assert property ( // R1
    @(posedge clk_i) disable iff (!rst_n_i)
    !active_o |-> !sample_supply_o && !sample_load_o && !gain_sel_20_o
    && !out_valid_o)
    else $error("path live in shutdown");
  a_gain_onehot: assert property ( // R6
    @(posedge clk_i) disable iff (!rst_n_i)
    active_o && shunt_gain_o != pwrmon_pkg::GAIN_UNDEF
    |-> $onehot({gain_sel_300_o, gain_sel_128_o, gain_sel_20_o}))
    else $error("shunt gain select not one hot");
  a_atten_onehot: assert property ( // R7
    @(posedge clk_i) disable iff (!rst_n_i)
    active_o && bus_atten_o != pwrmon_pkg::ATT_UNDEF
    |-> $onehot({atten_sel_1_10_o, atten_sel_1_5_o, atten_sel_2_5_o}))
    else $error("bus attenuation select not one hot");
  a_code_ok: assert property ( // R9
    @(posedge clk_i) disable iff (!rst_n_i)
    gain_code_ok_o == (shunt_gain_o != pwrmon_pkg::GAIN_UNDEF
    && bus_atten_o != pwrmon_pkg::ATT_UNDEF))
    else $error("gain code flag wrong");
  a_gain_table: assert property ( // R9
    @(posedge clk_i) disable iff (!rst_n_i)
    cfg_reg[3:0] == 4'h8 |-> power_gain_o == 16'h9C40)
    else $error("power gain 40 wrong");
  a_gain_least: assert property ( // R9
    @(posedge clk_i) disable iff (!rst_n_i)
    cfg_reg[3:0] == 4'h2 |-> power_gain_o == 16'h029B)
    else $error("power gain 0.667 wrong");
  a_gain_mid: assert property ( // R9
    @(posedge clk_i) disable iff (!rst_n_i)
    cfg_reg[3:0] == 4'h4 |-> power_gain_o == 16'h42AB)
    else $error("power gain 17.067 wrong");
endmodule : power_monitor_config_register

// ### cfg_master_model.sv
// two-wire master model handing words and general calls to the register
// assumes the bench calls xfer shortly after a rising clock edge
`timescale 1ns/100ps
module cfg_master_model (
  input wire logic clk_i,
  output logic wr_en_o,
  output logic [15:0] wr_data_o,
  output logic gc_valid_o,
  output logic [7:0] gc_cmd_o
);
  initial begin
    wr_en_o = 1'b0;
    wr_data_o = 16'h0000;
    gc_valid_o = 1'b0;
    gc_cmd_o = 8'h00;
  end
  // one transfer held for one edge, then strobes cleared and data and command inverted
  task automatic xfer(input logic w, input logic [15:0] d, input logic g,
                      input logic [7:0] c);
    if (d[3:2] == 2'h3) d[3] = 1'b0;
    if (d[1:0] == 2'h3) d[1] = 1'b0;
    wr_en_o = w;
    wr_data_o = d;
    gc_valid_o = g;
    gc_cmd_o = c;
    @(posedge clk_i);
    #1;
    wr_en_o = 1'b0;
    gc_valid_o = 1'b0;
    wr_data_o = ~d;
    gc_cmd_o = ~c;
  endtask : xfer
endmodule : cfg_master_model

// ### power_monitor_config_register_tb_top.sv
// self-checking bench for the configuration register and its decode
// assumes the master model drives all write and general call inputs
`timescale 1ns/100ps
module power_monitor_config_register_tb_top;
  localparam int unsigned WAKE = 10;
  logic clk_i = 1'b0;
  logic rst_n_i = 1'b0;
  logic wr_en_i, gc_valid_i, active_o, ss, sl, ok, ov;
  logic g20, g128, g300, a25, a15, a110;
  logic [15:0] wr_data_i, rd_data_o, power_gain_o, r;
  logic [7:0] gc_cmd_i;
  logic [1:0] mux_sel_o, shunt_gain_o, bus_atten_o;
  int error_cnt = 0, total_checks = 0, cyc = 0, m_reg = 0;
  int pg[$] = {2667, 17067, 40000, 1333, 8533, 20000, 667, 4267, 10000};
  function automatic logic [15:0] lfsr_next(input logic [15:0] v);
    return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
  endfunction : lfsr_next
  always #50 clk_i = ~clk_i;
  cfg_master_model mst (.clk_i(clk_i), .wr_en_o(wr_en_i),
    .wr_data_o(wr_data_i), .gc_valid_o(gc_valid_i), .gc_cmd_o(gc_cmd_i));
  power_monitor_config_register #(.WAKE_CYCLES(WAKE)) dut (.clk_i(clk_i),
    .rst_n_i(rst_n_i), .wr_en_i(wr_en_i), .wr_data_i(wr_data_i),
    .gc_valid_i(gc_valid_i), .gc_cmd_i(gc_cmd_i), .rd_data_o(rd_data_o),
    .active_o(active_o), .mux_sel_o(mux_sel_o), .sample_supply_o(ss),
    .sample_load_o(sl), .shunt_gain_o(shunt_gain_o),
    .bus_atten_o(bus_atten_o), .gain_sel_20_o(g20), .gain_sel_128_o(g128),
    .gain_sel_300_o(g300), .atten_sel_2_5_o(a25), .atten_sel_1_5_o(a15),
    .atten_sel_1_10_o(a110), .power_gain_o(power_gain_o),
    .gain_code_ok_o(ok), .out_valid_o(ov));
  task automatic chk(input string n, input logic [15:0] e,
                     input logic [15:0] s);
    total_checks++;
    if (s !== e) begin
      error_cnt++;
      $display("Error %s expected %h seen %h", n, e, s);
    end
  endtask : chk
  task automatic cmp_all;
    int a, m, g, b;
    a = (m_reg >> 6) & 1;
    m = (m_reg >> 4) & 3;
    g = (m_reg >> 2) & 3;
    b = m_reg & 3;
    chk("rd_data", 16'(m_reg), rd_data_o);
    chk("active", 16'(a), {15'h0000, active_o});
    chk("mux", 16'(m), {14'h0000, mux_sel_o});
    chk("shunt_gain", 16'(g), {14'h0000, shunt_gain_o});
    chk("bus_atten", 16'(b), {14'h0000, bus_atten_o});
    chk("supply", 16'(a && (m == 0 || m == 2)), {15'h0000, ss});
    chk("load", 16'(a && m == 3), {15'h0000, sl});
    chk("gain_sel", 16'(a ? (1 << g) : 0), {13'h0000, g300, g128, g20});
    chk("atten_sel", 16'(a ? (1 << b) : 0), {13'h0000, a110, a15, a25});
    chk("power_gain", 16'(pg[b * 3 + g]), power_gain_o);
    chk("code_ok", 16'h0001, {15'h0000, ok});
  endtask : cmp_all
  task automatic step(input logic w, input logic [15:0] d, input logic g,
                      input logic [7:0] c);
    if (d[3:2] == 2'h3) d[3] = 1'b0;
    if (d[1:0] == 2'h3) d[1] = 1'b0;
    mst.xfer(w, d, g, c);
    if (w) m_reg = d & 16'h007F;
    if (g && c == 8'h81) m_reg = m_reg | 16'h0040;
    if (g && c == 8'h82) m_reg = m_reg & 16'h003F;
    cmp_all();
    @(posedge clk_i);
    #1;
    cmp_all();
  endtask : step
  task automatic wrap_up;
    $display("checks %0d errors %0d", total_checks, error_cnt);
    if (error_cnt == 0 && total_checks > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : wrap_up
  always @(posedge clk_i) begin
    cyc++;
    if (cyc > 3000) begin
      error_cnt++;
      wrap_up();
    end
  end
  initial begin
    r = 16'h1682;
    repeat (5) @(posedge clk_i);
    #1 rst_n_i = 1'b1;
    m_reg = 'h61;
    cmp_all();
    chk("out_valid", 16'h0000, {15'h0000, ov});
    repeat (WAKE + 3) @(posedge clk_i);
    #1;
    chk("out_valid", 16'h0001, {15'h0000, ov});
    step(1'b1, 16'h0032, 1'b0, 8'h00);
    repeat (WAKE + 3) @(posedge clk_i);
    #1;
    chk("out_valid", 16'h0000, {15'h0000, ov});
    step(1'b0, 16'h0000, 1'b1, 8'h81);
    repeat (3) @(posedge clk_i);
    #1;
    chk("out_valid", 16'h0000, {15'h0000, ov});
    repeat (WAKE + 3) @(posedge clk_i);
    #1;
    chk("out_valid", 16'h0001, {15'h0000, ov});
    step(1'b1, 16'hFFFF, 1'b1, 8'h82);
    step(1'b0, 16'h0000, 1'b1, 8'h06);
    for (int k = 0; k < 64; k++) step(1'b1, 16'(k) | 16'hFFC0, 1'b0, 8'h00);
    for (int k = 0; k < 60; k++) begin
      r = lfsr_next(r);
      step(r[7], r, r[9], r[8] ? 8'h81 : 8'h82);
    end
    @(posedge clk_i) #1 rst_n_i = 1'b0;
    @(posedge clk_i) #1 rst_n_i = 1'b1;
    m_reg = 'h61;
    cmp_all();
    chk("out_valid", 16'h0000, {15'h0000, ov});
    repeat (WAKE + 3) @(posedge clk_i);
    #1;
    chk("out_valid", 16'h0001, {15'h0000, ov});
    wrap_up();
  end
endmodule : power_monitor_config_register_tb_top
